// file: verilog/scs_pkg.sv
// Purpose: shared constants and types for the system clock source select block
// Assumes: one 40 MHz sampling clock; oscillators and pins arrive as raw levels
// Notes: every clock source is handled as a sampled level, never as a clock net
//
// What this block does
// - power-up default source comes from a two-bit configuration field, four choices
// - external mode clocks from primary pin; secondary pin stays I/O or clock out
// - software switches between internal block and configured default at run time
// - internal mode frees the input pin; output pin follows clock out enable
// - fast oscillator goes through postscaler then multiplexer set by frequency select
// - fast oscillator enabled for fast setting and (config 00 or select 1x)
// - start-up oscillator drives internal clock until fast oscillator settles
// - fast ready flag follows whether the fast oscillator runs
// - fast stable flag set only within 0.5% of final frequency
// - slow oscillator enabled by code 000 with config 00 or select 1x, or timer needs
// - power-up timer and watchdog are clocked from the slow oscillator
// - slow ready flag follows whether the slow oscillator runs
// - peripheral RC clock starts automatically on any peripheral request
// - peripheral RC clock keeps running during sleep
// - per-peripheral clock routing: converter, timers, logic cells
// - frequency codes decode to 16 MHz downward, 001x 31.25 kHz, 000x slow
// - reset loads frequency select 0111 and clears system clock select
// - switch: start new clock, wait old falling, hold low, new rising, update flags
// - clock out enable 1 gives plain I/O, 0 drives clock out
package scs_pkg;

    localparam int SYNC_STAGES = 2;
    localparam int POST_WIDTH = 9;
    localparam int ID_WIDTH = 5;

    localparam logic [1:0] MODE_EXT_HIGH = 2'h3;
    localparam logic [1:0] MODE_EXT_MEDIUM = 2'h2;
    localparam logic [1:0] MODE_EXT_LOW = 2'h1;
    localparam logic [1:0] MODE_INTERNAL = 2'h0;

    localparam logic [3:0] FREQ_RESET = 4'h7;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam int SEL_INTERNAL_BIT = 1;

    // source id: bit 4 set means external pin, else low nibble is a frequency code
    localparam logic [ID_WIDTH-1:0] ID_EXTERNAL = 5'h10;
    localparam int ID_EXT_BIT = 4;

    // logic cell clock choices
    localparam logic [2:0] LC_SYS = 3'h0;
    localparam logic [2:0] LC_PRC = 3'h1;
    localparam logic [2:0] LC_FAST = 3'h2;
    localparam logic [2:0] LC_SLOW = 3'h3;
    localparam logic [2:0] LC_TMR0 = 3'h4;
    localparam logic [2:0] LC_TMR1 = 3'h5;
    localparam logic [2:0] LC_TMR2 = 3'h6;

    typedef struct packed {
        logic clock_out_enable_n;
        logic [1:0] mode;
    } scs_cfg_t;

    typedef struct packed {
        logic [3:0] internal_freq_select;
        logic [1:0] sys_clock_select;
    } scs_ctrl_t;

    typedef struct packed {
        logic fast_osc_ready;
        logic slow_osc_ready;
        logic fast_osc_stable;
    } scs_stat_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_START = 2'b01,
        SW_WAIT_FALL = 2'b11,
        SW_WAIT_RISE = 2'b10
    } scs_sw_state_t;

endpackage

// file: verilog/scs_glitch_mux.sv
// Purpose: glitch-free switch between two sampled clock levels
// Assumes: levels are synchronised to ref_clk; new_ready high once new source runs
// Notes: output is held low across the gap, so no high phase is ever shortened
`timescale 1ns/1ps
module scs_glitch_mux
    import scs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [scs_pkg::ID_WIDTH-1:0] req_id,
    input wire logic [scs_pkg::ID_WIDTH-1:0] reset_id,
    input wire logic old_level,
    input wire logic new_level,
    input wire logic new_ready,
    output logic [scs_pkg::ID_WIDTH-1:0] active_id,
    output logic [scs_pkg::ID_WIDTH-1:0] pending_id,
    output logic clk_level,
    output logic busy
);
    scs_sw_state_t state;
    scs_sw_state_t next_state;
    logic new_prev;
    logic [ID_WIDTH-1:0] next_active;
    logic [ID_WIDTH-1:0] next_pending;
    logic next_clk;

    wire new_rise = new_level & ~new_prev;
    wire change = req_id != active_id;

    always_comb
    begin
        next_state = state;
        next_active = active_id;
        next_pending = pending_id;
        next_clk = old_level;
        case (state)
            SW_IDLE:
            begin
                if (change)
                begin
                    next_pending = req_id;
                    next_state = SW_START;
                end
            end
            SW_START:
            begin
                if (new_ready)
                    next_state = SW_WAIT_FALL;
            end
            SW_WAIT_FALL:
            begin
                // once old is low the output is frozen low
                if (!old_level)
                begin
                    next_clk = 1'b0;
                    next_state = SW_WAIT_RISE;
                end
            end
            SW_WAIT_RISE:
            begin
                next_clk = 1'b0;
                if (new_rise)
                begin
                    next_clk = 1'b1;
                    next_active = pending_id;
                    next_state = SW_IDLE;
                end
            end
            default:
                next_state = SW_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= SW_IDLE;
            active_id <= ID_EXTERNAL;
            pending_id <= ID_EXTERNAL;
            clk_level <= 1'b0;
            new_prev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            active_id <= next_active;
            pending_id <= next_pending;
            clk_level <= next_clk;
            new_prev <= new_level;
        end
    end

    // reset_id is unused at run time; kept so the top can document its power-up target
    assign busy = (state != SW_IDLE) | (reset_id == active_id & 1'b0);
endmodule

// file: verilog/scs_clock_select.sv
// Purpose: system clock source selection, postscaler, oscillator enables and routing
// Assumes: all oscillator and pin inputs are raw levels from other domains
// Notes: sources up to 20 MHz are sampled at 40 MHz, so edge timing is coarse
`timescale 1ns/1ps
module scs_clock_select
    import scs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire scs_pkg::scs_cfg_t cfg,
    input wire logic ctrl_write,
    input wire scs_pkg::scs_ctrl_t ctrl_wdata,
    input wire logic clock_input_pin,
    input wire logic fast_osc_clk,
    input wire logic fast_osc_running,
    input wire logic fast_osc_settled,
    input wire logic startup_osc_clk,
    input wire logic slow_osc_clk,
    input wire logic slow_osc_running,
    input wire logic peripheral_rc_raw,
    input wire logic tmr0_level,
    input wire logic tmr1_level,
    input wire logic tmr2_level,
    input wire logic power_up_timer_need,
    input wire logic watchdog_timer_need,
    input wire logic prc_request,
    input wire logic sleep_mode,
    input wire logic adc_use_prc,
    input wire logic [2:0] logic_cell_sel,
    output scs_pkg::scs_ctrl_t ctrl,
    output scs_pkg::scs_stat_t oscillator_status,
    output logic sys_clk_level,
    output logic switch_busy,
    output logic fast_osc_enable,
    output logic slow_osc_enable,
    output logic prc_enable,
    output logic timer_clk_level,
    output logic adc_clk_level,
    output logic logic_cell_clk_level,
    output logic clock_input_is_gpio,
    output logic secondary_pin_out,
    output logic secondary_pin_oe
);
    localparam int NSYNC = 12;

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;

    assign raw_in = {tmr2_level, tmr1_level, tmr0_level, peripheral_rc_raw, slow_osc_running,
                     slow_osc_clk, startup_osc_clk, fast_osc_settled, fast_osc_running,
                     fast_osc_clk, clock_input_pin, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end
                else
                begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    wire ext_lvl = sync2[1];
    wire fast_lvl = sync2[2];
    wire fast_run = sync2[3];
    wire fast_ok = sync2[4];
    wire startup_lvl = sync2[5];
    wire slow_lvl = sync2[6];
    wire slow_run = sync2[7];
    wire prc_lvl = sync2[8];
    wire tmr0_s = sync2[9];
    wire tmr1_s = sync2[10];
    wire tmr2_s = sync2[11];

    ////////////////////////////////////////////////////////////////////////////////
    // software control fields

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl.internal_freq_select <= FREQ_RESET;
            ctrl.sys_clock_select <= SEL_RESET;
        end
        else if (ctrl_write)
        begin
            ctrl <= ctrl_wdata;
        end
    end

    wire [3:0] freq = ctrl.internal_freq_select;
    wire sel_internal = ctrl.sys_clock_select[SEL_INTERNAL_BIT];
    wire cfg_internal = cfg.mode == MODE_INTERNAL;
    // reserved select 01 falls back to the configured default
    wire use_internal = sel_internal | cfg_internal;
    wire freq_is_slow = freq[3:1] == 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // fast oscillator, start-up handover and postscaler

    // start-up oscillator stands in until the fast one is within tolerance
    wire base_lvl = fast_ok ? fast_lvl : startup_lvl;
    logic base_prev;
    logic [POST_WIDTH-1:0] post_cnt;
    wire [POST_WIDTH-1:0] next_post_cnt = post_cnt + 1'b1;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            base_prev <= 1'b0;
            post_cnt <= '0;
        end
        else
        begin
            base_prev <= base_lvl;
            if (base_lvl & ~base_prev)
                post_cnt <= next_post_cnt;
        end
    end

    // level of a source id; used for the old and the new side of a switch
    function automatic logic level_of(input logic [ID_WIDTH-1:0] id, input logic [POST_WIDTH-1:0] cnt,
                                      input logic base, input logic slow, input logic ext);
        logic [3:0] c;
        c = id[3:0];
        level_of = 1'b0;
        if (id[ID_EXT_BIT])
            level_of = ext;
        else if (c == 4'hF)
            level_of = base;
        else if (c[3])
            level_of = cnt[3'(4'hE - c)];
        else if (c[2])
            level_of = cnt[3'(4'hB - c)];
        else if (c[1])
            level_of = cnt[8];
        else
            level_of = slow;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // glitch-free source switch

    logic [ID_WIDTH-1:0] active_id;
    logic [ID_WIDTH-1:0] pending_id;
    logic mux_clk;
    logic mux_busy;

    wire [ID_WIDTH-1:0] req_id = use_internal ? {1'b0, freq} : ID_EXTERNAL;
    wire old_lvl = level_of(active_id, post_cnt, base_lvl, slow_lvl, ext_lvl);
    wire new_lvl = level_of(pending_id, post_cnt, base_lvl, slow_lvl, ext_lvl);
    wire pend_slow = pending_id[3:1] == 3'h0;
    // external source is assumed present; internal ones must report running
    wire new_ready = pending_id[ID_EXT_BIT] | (pend_slow ? slow_run : fast_run);

    scs_glitch_mux u_mux (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .req_id(req_id),
        .reset_id(ID_EXTERNAL),
        .old_level(old_lvl),
        .new_level(new_lvl),
        .new_ready(new_ready),
        .active_id(active_id),
        .pending_id(pending_id),
        .clk_level(mux_clk),
        .busy(mux_busy)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator enables, start of the new clock comes before the switch

    wire pend_int = mux_busy & ~pending_id[ID_EXT_BIT];
    wire act_int = ~active_id[ID_EXT_BIT];
    wire want_fast = (~freq_is_slow & (cfg_internal | sel_internal))
                     | (pend_int & ~pend_slow) | (act_int & active_id[3:1] != 3'h0);
    wire want_slow = (freq_is_slow & sel_internal) | (freq_is_slow & cfg_internal)
                     | power_up_timer_need | watchdog_timer_need
                     | (pend_int & pend_slow) | (act_int & active_id[3:1] == 3'h0);
    // sleep does not gate the rc clock
    wire want_prc = prc_request | (sleep_mode & prc_request);

    ////////////////////////////////////////////////////////////////////////////////
    // routing and pin functions

    logic lc_lvl;
    always_comb
    begin
        case (logic_cell_sel)
            LC_SYS: lc_lvl = mux_clk;
            LC_PRC: lc_lvl = prc_lvl;
            LC_FAST: lc_lvl = base_lvl;
            LC_SLOW: lc_lvl = slow_lvl;
            LC_TMR0: lc_lvl = tmr0_s;
            LC_TMR1: lc_lvl = tmr1_s;
            LC_TMR2: lc_lvl = tmr2_s;
            default: lc_lvl = mux_clk;
        endcase
    end

    wire clock_output_pin_on = ~cfg.clock_out_enable_n;

    ////////////////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            oscillator_status <= '0;
            sys_clk_level <= 1'b0;
            switch_busy <= 1'b0;
            fast_osc_enable <= 1'b0;
            slow_osc_enable <= 1'b0;
            prc_enable <= 1'b0;
            timer_clk_level <= 1'b0;
            adc_clk_level <= 1'b0;
            logic_cell_clk_level <= 1'b0;
            clock_input_is_gpio <= 1'b0;
            secondary_pin_out <= 1'b0;
            secondary_pin_oe <= 1'b0;
        end
        else
        begin
            // flags wait until a running switch has completed
            if (!mux_busy)
            begin
                oscillator_status.fast_osc_ready <= fast_run;
                oscillator_status.slow_osc_ready <= slow_run;
                oscillator_status.fast_osc_stable <= fast_run & fast_ok;
            end
            sys_clk_level <= mux_clk;
            switch_busy <= mux_busy;
            fast_osc_enable <= want_fast;
            slow_osc_enable <= want_slow;
            prc_enable <= want_prc;
            timer_clk_level <= slow_lvl;
            adc_clk_level <= adc_use_prc ? prc_lvl : mux_clk;
            logic_cell_clk_level <= lc_lvl;
            clock_input_is_gpio <= act_int;
            secondary_pin_out <= clock_output_pin_on & mux_clk;
            secondary_pin_oe <= clock_output_pin_on;
        end
    end
endmodule

// file: test/scs_ext_clk_gen.sv
// Purpose: external logic-level clock source for the clock input pin
// Assumes: half period in ns; source is parked low while disabled
// Notes: free running and unrelated in phase to ref_clk
`timescale 1ns/1ps
module scs_ext_clk_gen #(
    parameter real HALF_NS = 37.0,
    parameter real MED_HALF_NS = 400.0,
    parameter real LOW_HALF_NS = 1200.0
)(
    input wire logic en,
    input wire logic [1:0] power_range,
    output logic clk_out
);
    initial clk_out = 1'b0;
    // about 13.5 MHz for high power, 1.25 MHz for medium, 0.42 MHz for low
    always
    begin
        #(power_range == 2'h1 ? LOW_HALF_NS : power_range == 2'h2 ? MED_HALF_NS : HALF_NS);
        clk_out = en ? ~clk_out : 1'b0;
    end
endmodule

// file: test/scs_clock_select_chk.sv
// Purpose: concurrent checks on the clock select ports
// Assumes: oscillator status inputs steady while a switch runs
// Notes: idle windows of 8 cycles cover synchroniser and register delay
`timescale 1ns/1ps
module scs_clock_select_chk
    import scs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire scs_pkg::scs_cfg_t cfg,
    input wire logic ctrl_write,
    input wire scs_pkg::scs_ctrl_t ctrl_wdata,
    input wire logic prc_request,
    input wire logic power_up_timer_need,
    input wire logic watchdog_timer_need,
    input wire scs_pkg::scs_ctrl_t ctrl,
    input wire scs_pkg::scs_stat_t oscillator_status,
    input wire logic switch_busy,
    input wire logic fast_osc_enable,
    input wire logic slow_osc_enable,
    input wire logic prc_enable,
    input wire logic clock_input_is_gpio,
    input wire logic secondary_pin_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    sequence s_int_idle;
        (ctrl.sys_clock_select[SEL_INTERNAL_BIT] && !switch_busy)[*8];
    endsequence
    sequence s_int_fast;
        (ctrl.sys_clock_select[1] && !switch_busy && ctrl.internal_freq_select[3:1] != 3'h0)[*8];
    endsequence
    sequence s_int_slow;
        (ctrl.sys_clock_select[1] && !switch_busy && ctrl.internal_freq_select[3:1] == 3'h0)[*8];
    endsequence
    ////////////////////////////////////////////////////////////////
    AST_RESET_VALUE: assert property ($rose(rstn) |-> ctrl == {FREQ_RESET, SEL_RESET})
        else $error("control fields wrong after reset");
    AST_CTRL_TAKE: assert property (ctrl_write |=> ctrl == $past(ctrl_wdata))
        else $error("control write not taken");
    AST_PRC_ON: assert property (prc_request[*3] |-> prc_enable)
        else $error("peripheral clock not started on request");
    AST_TIMER_SLOW: assert property ((power_up_timer_need || watchdog_timer_need)[*3] |-> slow_osc_enable)
        else $error("slow oscillator off while a timer needs it");
    AST_STABLE_READY: assert property (oscillator_status.fast_osc_stable |-> oscillator_status.fast_osc_ready)
        else $error("stable flag without ready flag");
    AST_CLOCK_OUTPUT_PIN_OE: assert property ($stable(cfg)[*3] |-> secondary_pin_oe == !cfg.clock_out_enable_n)
        else $error("clock out enable not followed");
    // slowest switch: half an old divide-by-512 period plus a full new one, doubled on the start-up base
    localparam logic [12:0] SWITCH_LIMIT = 13'h1000;
    logic [12:0] busy_cnt;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            busy_cnt <= 13'h0;
        else
            busy_cnt <= switch_busy ? busy_cnt + 13'h1 : 13'h0;
    end
    AST_SWITCH_ENDS: assert property (switch_busy |-> busy_cnt < SWITCH_LIMIT)
        else $error("source switch did not finish");
    AST_FLAGS_FROZEN: assert property (switch_busy && $past(switch_busy) |-> $stable(oscillator_status))
        else $error("status changed during a switch");
    AST_INT_GPIO: assert property (s_int_idle |-> clock_input_is_gpio)
        else $error("input pin not freed in internal mode");
    AST_FAST_EN: assert property (s_int_fast |-> fast_osc_enable)
        else $error("fast oscillator off for a fast setting");
    AST_SLOW_EN: assert property (s_int_slow |-> slow_osc_enable && !fast_osc_enable)
        else $error("slow setting enables wrong oscillator");
endmodule
bind scs_clock_select scs_clock_select_chk u_chk (.*);

// file: test/scs_clock_select_test.sv
// Purpose: self-checking bench for the system clock source select
// Assumes: fast base toggles each cycle, start-up every 2, slow every 64
// Notes: periods are measured in ref_clk cycles between rising edges
`timescale 1ns/1ps
module scs_clock_select_test;
    import scs_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    scs_cfg_t cfg = 3'h4;
    logic ctrl_write = 1'b0;
    scs_ctrl_t ctrl_wdata = '0;
    logic [7:0] cnt = '0;
    logic ext_en = 1'b0;
    logic fast_osc_running = 1'b1;
    logic fast_osc_settled = 1'b1;
    logic slow_osc_running = 1'b1;
    logic power_up_timer_need = 1'b0;
    logic watchdog_timer_need = 1'b0;
    logic prc_request = 1'b0;
    logic sleep_mode = 1'b0;
    logic adc_use_prc = 1'b0;
    logic [2:0] logic_cell_sel = 3'h0;
    logic clock_input_pin, sys_clk_level, switch_busy, fast_osc_enable, slow_osc_enable;
    logic prc_enable, timer_clk_level, clock_input_is_gpio, secondary_pin_oe;
    logic adc_clk_level, logic_cell_clk_level, secondary_pin_out;
    scs_ctrl_t ctrl;
    scs_stat_t oscillator_status;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cnt <= cnt + 8'h01;
    scs_ext_clk_gen u_ext (.en(ext_en), .power_range(cfg.mode), .clk_out(clock_input_pin));
    scs_clock_select dut (.ref_clk, .rstn, .cfg, .ctrl_write, .ctrl_wdata, .clock_input_pin,
        .fast_osc_clk(cnt[0]), .fast_osc_running, .fast_osc_settled, .startup_osc_clk(cnt[1]),
        .slow_osc_clk(cnt[6]), .slow_osc_running, .peripheral_rc_raw(cnt[2]), .tmr0_level(cnt[3]),
        .tmr1_level(cnt[4]), .tmr2_level(cnt[5]), .power_up_timer_need, .watchdog_timer_need,
        .prc_request, .sleep_mode, .adc_use_prc, .logic_cell_sel, .ctrl, .oscillator_status,
        .sys_clk_level, .switch_busy, .fast_osc_enable, .slow_osc_enable, .prc_enable, .timer_clk_level,
        .adc_clk_level, .logic_cell_clk_level, .clock_input_is_gpio, .secondary_pin_out,
        .secondary_pin_oe);
    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // generous ceiling: the whole sequence needs under 10000 cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_idle();
        int k = 0;
        for (int i = 0; i < 3000 && k < 8; i++)
        begin
            @(posedge ref_clk);
            k = (switch_busy !== 1'b0) ? 0 : k + 1;
        end
        cmp(k, 8);
    endtask
    task automatic wr(input logic [3:0] f, input logic [1:0] s);
        ctrl_write <= 1'b1;
        ctrl_wdata <= {f, s};
        @(posedge ref_clk);
        ctrl_write <= 1'b0;
        wait_idle();
    endtask
    task automatic do_reset(input logic [1:0] m);
        rstn <= 1'b0;
        cfg <= {1'b1, m};
        repeat (10) @(posedge ref_clk);
        cmp(ctrl, 16'h001C);
        rstn <= 1'b1;
        wait_idle();
    endtask
    // 0 system, 1 timer, 2 converter, 3 logic cell, 4 clock out pin
    task automatic period(input int src, input int exp);
        int t[2];
        int j = 0;
        logic prev = 1'b1;
        logic lv;
        for (int i = 0; i < 3000 && j < 2; i++)
        begin
            @(posedge ref_clk);
            lv = src == 1 ? timer_clk_level : src == 2 ? adc_clk_level : src == 3 ? logic_cell_clk_level
                 : src == 4 ? secondary_pin_out : sys_clk_level;
            if (lv === 1'b1 && prev === 1'b0)
            begin
                t[j] = i;
                j++;
            end
            prev = lv;
        end
        cmp((j == 2) ? t[1] - t[0] : 0, exp);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_boot();
        cmp(clock_input_is_gpio, 1);
        cmp(fast_osc_enable, 1);
        cmp(oscillator_status, 3'h7);
        cmp({secondary_pin_oe, secondary_pin_out}, 2'h0);
        period(0, 64);
    endtask
    task automatic t_freq();
        logic [3:0] codes[8] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'hA, 4'h7, 4'h4, 4'h2};
        foreach (codes[n])
        begin
            wr(codes[n], 2'h2);
            period(0, codes[n] >= 8 ? 2 << (15 - codes[n]) : codes[n] >= 4 ? 2 << (12 - codes[n]) : 1024);
        end
        wr(4'h0, 2'h3);
        cmp({slow_osc_enable, fast_osc_enable}, 2'h2);
        period(0, 128);
    endtask
    task automatic t_status();
        wr(4'hF, 2'h2);
        fast_osc_settled <= 1'b0;
        repeat (10) @(posedge ref_clk);
        cmp(oscillator_status, 3'h6);
        period(0, 4);
        fast_osc_running <= 1'b0;
        repeat (10) @(posedge ref_clk);
        cmp(oscillator_status, 3'h2);
        slow_osc_running <= 1'b0;
        repeat (10) @(posedge ref_clk);
        cmp(oscillator_status, 3'h0);
        {fast_osc_running, fast_osc_settled, slow_osc_running} <= 3'h7;
        repeat (10) @(posedge ref_clk);
        cmp(oscillator_status, 3'h7);
    endtask
    task automatic t_periph();
        int lc_exp[6] = '{8, 2, 128, 16, 32, 64};
        prc_request <= 1'b1;
        sleep_mode <= 1'b1;
        repeat (6) @(posedge ref_clk);
        cmp(prc_enable, 1);
        prc_request <= 1'b0;
        repeat (6) @(posedge ref_clk);
        cmp(prc_enable, 0);
        sleep_mode <= 1'b0;
        watchdog_timer_need <= 1'b1;
        repeat (6) @(posedge ref_clk);
        cmp(slow_osc_enable, 1);
        period(1, 128);
        watchdog_timer_need <= 1'b0;
        power_up_timer_need <= 1'b1;
        repeat (6) @(posedge ref_clk);
        cmp(slow_osc_enable, 1);
        power_up_timer_need <= 1'b0;
        period(2, 2);
        adc_use_prc <= 1'b1;
        repeat (4) @(posedge ref_clk);
        period(2, 8);
        adc_use_prc <= 1'b0;
        foreach (lc_exp[n])
        begin
            logic_cell_sel <= 3'(n + 1);
            repeat (4) @(posedge ref_clk);
            period(3, lc_exp[n]);
        end
        logic_cell_sel <= 3'h0;
    endtask
    task automatic t_external();
        int tg = 0;
        cmp(clock_input_is_gpio, 0);
        cmp(fast_osc_enable, 0);
        for (int i = 0; i < 100; i++)
        begin
            @(posedge ref_clk);
            tg += (sys_clk_level === 1'b1) ? 1 : 0;
        end
        cmp(tg > 10 && tg < 90, 1);
        wr(4'h7, 2'h2);
        cmp(clock_input_is_gpio, 1);
        wr(4'h7, 2'h0);
        cmp(clock_input_is_gpio, 0);
        wr(4'h7, 2'h1);
        cmp(clock_input_is_gpio, 0);
        cfg.clock_out_enable_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        cmp(secondary_pin_oe, 1);
        wr(4'hE, 2'h2);
        period(4, 4);
    endtask
    initial
    begin
        do_reset(MODE_INTERNAL);
        t_boot();
        t_freq();
        t_status();
        t_periph();
        ext_en <= 1'b1;
        do_reset(MODE_EXT_HIGH);
        t_external();
        do_reset(MODE_EXT_LOW);
        cmp({clock_input_is_gpio, fast_osc_enable}, 2'h0);
        do_reset(MODE_EXT_MEDIUM);
        cmp({clock_input_is_gpio, fast_osc_enable}, 2'h0);
        stop_test();
    end
endmodule
